// File: logic/secl_loader.sv
// What this block does
// - Byte 00 gives max latency and min grant
// - Subsystem ID: byte 03 low, 04 high
// - Byte 16 bit 7 enables cable-not-active output
// - Byte 14 bits 7-3 give card info pointer
// - Retry all PCI slave accesses while loading
`timescale 1ns/100ps
module secl_loader (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Serial EEPROM pins, open drain
   output logic scl_o,
   output logic scl_oe_o,
   input wire logic sda_i,
   output logic sda_o,
   output logic sda_oe_o,
   // Load status
   output logic pci_retry_o,
   output logic load_done_o,
   output logic eeprom_absent_o,
   // Loaded configuration fields
   output logic [3:0] max_latency_o,
   output logic [3:0] min_grant_o,
   output logic [15:0] vendor_id_o,
   output logic [15:0] subsystem_id_o,
   output logic enab_unfair_o,
   output logic phy_programming_permit_o,
   output logic enab_accel_o,
   output logic [63:0] guid_o,
   output logic async_tx_pipeline_disable_o,
   output logic [1:0] async_tx_threshold_o,
   output logic target_abort_disable_o,
   output logic pme_d3_cold_o,
   output logic [4:0] card_info_pointer_o,
   output logic [7:0] phy_control_o,
   output logic cable_not_active_output_o
);
   import secl_pkg::*;

   secl_twi_if twi ();

   secl_twi_engine u_engine (
      .core_clk_i (core_clk_i),
      .reset_i (reset_i),
      .twi (twi)
   );

   secl_load_state_t state, next_state;
   logic issued, next_issued;
   logic cmd_valid, next_cmd_valid;
   secl_cmd_t cmd, next_cmd;
   logic [7:0] wdata, next_wdata;
   logic [4:0] addr, next_addr;
   logic absent, next_absent;
   logic retry, next_retry;
   logic img_we;
   logic [7:0] img [0:22];

   assign twi.cmd_valid = cmd_valid;
   assign twi.cmd = cmd;
   assign twi.wdata = wdata;
   assign twi.master_ack = (addr != SECL_IMG_LAST);
   assign twi.sda_pin = sda_i;

   // ---------------------------------------------------------------
   // Load sequencer
   // ---------------------------------------------------------------
   // One command per state, one per image byte in SECL_L_READ; a missing acknowledge on the device address
   // means no EEPROM, so the defaults stay and loading ends early
   always_comb begin
      next_state = state;
      next_issued = issued;
      next_cmd_valid = 1'b0;
      next_cmd = cmd;
      next_wdata = wdata;
      next_addr = addr;
      next_absent = absent;
      next_retry = retry;
      img_we = 1'b0;
      if (state != SECL_L_DONE && !issued) begin
         next_issued = 1'b1;
         next_cmd_valid = 1'b1;
         case (state)
            SECL_L_START1, SECL_L_START2: next_cmd = SECL_CMD_START;
            SECL_L_DEVW: begin
               next_cmd = SECL_CMD_WRITE;
               next_wdata = SECL_DEV_WRITE;
            end
            SECL_L_WADDR: begin
               next_cmd = SECL_CMD_WRITE;
               next_wdata = {3'h0, SECL_IMG_FIRST};
            end
            SECL_L_DEVR: begin
               next_cmd = SECL_CMD_WRITE;
               next_wdata = SECL_DEV_READ;
            end
            SECL_L_READ: next_cmd = SECL_CMD_READ;
            default: next_cmd = SECL_CMD_STOP;
         endcase
      end
      if (twi.done) begin
         next_issued = 1'b0;
         case (state)
            SECL_L_START1: next_state = SECL_L_DEVW;
            SECL_L_DEVW: begin
               next_absent = !twi.ack_seen;
               next_state = twi.ack_seen ? SECL_L_WADDR : SECL_L_STOP;
            end
            SECL_L_WADDR: next_state = SECL_L_START2;
            SECL_L_START2: next_state = SECL_L_DEVR;
            SECL_L_DEVR: next_state = SECL_L_READ;
            SECL_L_READ: begin
               // Ascending sequential read, last byte not acknowledged
               img_we = 1'b1;
               if (addr == SECL_IMG_LAST) begin
                  next_state = SECL_L_STOP;
               end else begin
                  next_addr = addr + 5'h01;
               end
            end
            SECL_L_STOP: begin
               // Retry ends once the stop is sent, after the whole image or a missing device ack
               next_state = SECL_L_DONE;
               next_retry = 1'b0;
            end
            default: next_state = SECL_L_DONE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= SECL_L_START1;
         issued <= 1'b0;
         cmd_valid <= 1'b0;
         cmd <= SECL_CMD_START;
         wdata <= 8'h00;
         addr <= SECL_IMG_FIRST;
         absent <= 1'b0;
         retry <= 1'b1;
      end else begin
         state <= next_state;
         issued <= next_issued;
         cmd_valid <= next_cmd_valid;
         cmd <= next_cmd;
         wdata <= next_wdata;
         addr <= next_addr;
         absent <= next_absent;
         retry <= next_retry;
      end
   end

   // Image store; no reset needed, fields only read after a full load
   always_ff @(posedge core_clk_i) begin
      if (img_we) begin
         img[addr] <= twi.rdata;
      end
   end

   // ---------------------------------------------------------------
   // Field mapping
   // ---------------------------------------------------------------
   // Fields copy from the image in the cycle retry drops. Reserved
   // image bits are never looked at; the image must keep them as
   // required else the outputs carry what it holds
   logic commit;
   assign commit = twi.done && state == SECL_L_STOP && !absent;

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         max_latency_o <= 4'h0;
         min_grant_o <= 4'h0;
         vendor_id_o <= 16'h0000;
         subsystem_id_o <= 16'h0000;
         enab_unfair_o <= 1'b0;
         phy_programming_permit_o <= 1'b0;
         enab_accel_o <= 1'b0;
         guid_o <= 64'h0000000000000000;
         async_tx_pipeline_disable_o <= 1'b0;
         async_tx_threshold_o <= 2'h0;
         target_abort_disable_o <= 1'b0;
         pme_d3_cold_o <= 1'b0;
         card_info_pointer_o <= 5'h00;
         phy_control_o <= 8'h00;
         cable_not_active_output_o <= 1'b0;
      end else if (commit) begin
         max_latency_o <= img[SECL_OFS_LAT_GNT][SECL_LAT_HI:SECL_LAT_LO];
         min_grant_o <= img[SECL_OFS_LAT_GNT][SECL_GNT_HI:SECL_GNT_LO];
         vendor_id_o <= {img[SECL_OFS_VEN_HI], img[SECL_OFS_VEN_LO]};
         subsystem_id_o <= {img[SECL_OFS_SUB_HI], img[SECL_OFS_SUB_LO]};
         enab_unfair_o <= img[SECL_OFS_LINK][SECL_BIT_UNFAIR];
         phy_programming_permit_o <= img[SECL_OFS_LINK][SECL_BIT_PHYPROG];
         enab_accel_o <= img[SECL_OFS_LINK][SECL_BIT_ACCEL];
         guid_o <= {img[SECL_OFS_GUID_HI + 5'h03], img[SECL_OFS_GUID_HI + 5'h02],
                    img[SECL_OFS_GUID_HI + 5'h01], img[SECL_OFS_GUID_HI],
                    img[SECL_OFS_GUID_LO + 5'h03], img[SECL_OFS_GUID_LO + 5'h02],
                    img[SECL_OFS_GUID_LO + 5'h01], img[SECL_OFS_GUID_LO]};
         async_tx_pipeline_disable_o <= img[SECL_OFS_ATX][SECL_BIT_ATX_DIS];
         async_tx_threshold_o <= img[SECL_OFS_ATX][SECL_ATX_THR_HI:SECL_ATX_THR_LO];
         target_abort_disable_o <= img[SECL_OFS_MISC][SECL_BIT_TABORT];
         pme_d3_cold_o <= img[SECL_OFS_PME][SECL_BIT_PME];
         card_info_pointer_o <= img[SECL_OFS_CIS][SECL_CIS_HI:SECL_CIS_LO];
         phy_control_o <= img[SECL_OFS_PHY];
         cable_not_active_output_o <= img[SECL_OFS_PHY][SECL_BIT_CNA];
      end
   end

   // ---------------------------------------------------------------
   // Status and pins
   // ---------------------------------------------------------------
   // Open drain: the pins only ever drive low
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_o <= 1'b0;
         sda_oe_o <= 1'b0;
         pci_retry_o <= 1'b1;
         load_done_o <= 1'b0;
         eeprom_absent_o <= 1'b0;
      end else begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         scl_oe_o <= twi.scl_oe;
         sda_oe_o <= twi.sda_oe;
         pci_retry_o <= retry;
         load_done_o <= !retry;
         eeprom_absent_o <= absent;
      end
   end

endmodule

// File: logic/secl_pkg.sv
package secl_pkg;

   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int SECL_CLK_PERIOD_NS = 100;
   // Quarter of a 100 kHz serial bit; a least time, so it rounds up
   localparam int SECL_QUARTER_NS = 2500;
   localparam logic [7:0] SECL_QUARTER_CYC =
      8'((SECL_QUARTER_NS + SECL_CLK_PERIOD_NS - 1) / SECL_CLK_PERIOD_NS);

   // ---------------------------------------------------------------
   // Serial frame
   // ---------------------------------------------------------------
   localparam logic [7:0] SECL_DEV_WRITE = 8'hA0;
   localparam logic [7:0] SECL_DEV_READ = 8'hA1;
   localparam logic [3:0] SECL_ACK_BIT = 4'h8;
   localparam logic [1:0] SECL_LAST_PHASE = 2'h3;

   // ---------------------------------------------------------------
   // Image byte offsets
   // ---------------------------------------------------------------
   localparam logic [4:0] SECL_IMG_FIRST = 5'h00;
   localparam logic [4:0] SECL_IMG_LAST = 5'h16;
   localparam logic [4:0] SECL_OFS_LAT_GNT = 5'h00;
   localparam logic [4:0] SECL_OFS_VEN_LO = 5'h01;
   localparam logic [4:0] SECL_OFS_VEN_HI = 5'h02;
   localparam logic [4:0] SECL_OFS_SUB_LO = 5'h03;
   localparam logic [4:0] SECL_OFS_SUB_HI = 5'h04;
   localparam logic [4:0] SECL_OFS_LINK = 5'h05;
   localparam logic [4:0] SECL_OFS_GUID_HI = 5'h07;
   localparam logic [4:0] SECL_OFS_GUID_LO = 5'h0B;
   localparam logic [4:0] SECL_OFS_ATX = 5'h10;
   localparam logic [4:0] SECL_OFS_MISC = 5'h11;
   localparam logic [4:0] SECL_OFS_PME = 5'h12;
   localparam logic [4:0] SECL_OFS_CIS = 5'h14;
   localparam logic [4:0] SECL_OFS_PHY = 5'h16;

   // ---------------------------------------------------------------
   // Field positions inside image bytes
   // ---------------------------------------------------------------
   localparam int SECL_LAT_HI = 7;
   localparam int SECL_LAT_LO = 4;
   localparam int SECL_GNT_HI = 3;
   localparam int SECL_GNT_LO = 0;
   localparam int SECL_BIT_UNFAIR = 7;
   localparam int SECL_BIT_PHYPROG = 6;
   localparam int SECL_BIT_ACCEL = 1;
   localparam int SECL_BIT_ATX_DIS = 7;
   localparam int SECL_ATX_THR_HI = 5;
   localparam int SECL_ATX_THR_LO = 4;
   localparam int SECL_BIT_TABORT = 4;
   localparam int SECL_BIT_PME = 7;
   localparam int SECL_CIS_HI = 7;
   localparam int SECL_CIS_LO = 3;
   localparam int SECL_BIT_CNA = 7;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SECL_CMD_START = 2'h0,
      SECL_CMD_WRITE = 2'h1,
      SECL_CMD_READ = 2'h2,
      SECL_CMD_STOP = 2'h3
   } secl_cmd_t;

   typedef enum logic [3:0] {
      SECL_E_IDLE = 4'h1,
      SECL_E_START = 4'h2,
      SECL_E_BIT = 4'h4,
      SECL_E_STOP = 4'h8
   } secl_eng_state_t;

   typedef enum logic [7:0] {
      SECL_L_START1 = 8'h01,
      SECL_L_DEVW = 8'h02,
      SECL_L_WADDR = 8'h04,
      SECL_L_START2 = 8'h08,
      SECL_L_DEVR = 8'h10,
      SECL_L_READ = 8'h20,
      SECL_L_STOP = 8'h40,
      SECL_L_DONE = 8'h80
   } secl_load_state_t;

endpackage

// File: logic/secl_twi_engine.sv
`timescale 1ns/100ps
module secl_twi_engine (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Loader side and pins
   secl_twi_if.engine twi
);
   import secl_pkg::*;

   secl_eng_state_t state, next_state;
   logic [1:0] phase, next_phase;
   logic [7:0] timer, next_timer;
   logic [3:0] bitn, next_bitn;
   logic [7:0] shreg, next_shreg;
   secl_cmd_t cmd_r, next_cmd_r;
   logic mack, next_mack;
   logic scl_oe, next_scl_oe;
   logic sda_oe, next_sda_oe;
   logic done, next_done;
   logic [7:0] rdata, next_rdata;
   logic ack_seen, next_ack_seen;
   logic sda_meta, sda_sync;

   assign twi.scl_oe = scl_oe;
   assign twi.sda_oe = sda_oe;
   assign twi.done = done;
   assign twi.rdata = rdata;
   assign twi.ack_seen = ack_seen;

   // ---------------------------------------------------------------
   // Bit sequencer
   // ---------------------------------------------------------------
   // Each bit is four quarter phases; pin actions happen on phase entry
   always_comb begin
      next_state = state;
      next_phase = phase;
      next_timer = timer;
      next_bitn = bitn;
      next_shreg = shreg;
      next_cmd_r = cmd_r;
      next_mack = mack;
      next_scl_oe = scl_oe;
      next_sda_oe = sda_oe;
      next_done = 1'b0;
      next_rdata = rdata;
      next_ack_seen = ack_seen;
      if (state == SECL_E_IDLE) begin
         if (twi.cmd_valid) begin
            next_cmd_r = twi.cmd;
            next_shreg = twi.wdata;
            next_mack = twi.master_ack;
            next_phase = 2'h0;
            next_timer = 8'h00;
            next_bitn = 4'h0;
            case (twi.cmd)
               SECL_CMD_START: next_state = SECL_E_START;
               SECL_CMD_STOP: next_state = SECL_E_STOP;
               default: next_state = SECL_E_BIT;
            endcase
         end
      end else begin
         if (timer == 8'h00) begin
            case (state)
               SECL_E_START: begin
                  // Release data, raise clock, then data falls while clock high
                  case (phase)
                     2'h0: next_sda_oe = 1'b0;
                     2'h1: next_scl_oe = 1'b0;
                     2'h2: next_sda_oe = 1'b1;
                     default: next_scl_oe = 1'b1;
                  endcase
               end
               SECL_E_STOP: begin
                  case (phase)
                     2'h0: next_sda_oe = 1'b1;
                     2'h1: next_scl_oe = 1'b0;
                     2'h2: next_sda_oe = 1'b0;
                     default: next_sda_oe = 1'b0;
                  endcase
               end
               default: begin
                  case (phase)
                     2'h0: begin
                        if (bitn == SECL_ACK_BIT) begin
                           // Pull low only to acknowledge a read byte
                           next_sda_oe = (cmd_r == SECL_CMD_READ) && mack;
                        end else begin
                           next_sda_oe = (cmd_r == SECL_CMD_WRITE) && !shreg[7];
                        end
                     end
                     2'h1: next_scl_oe = 1'b0;
                     2'h2: begin
                        if (bitn == SECL_ACK_BIT) begin
                           next_ack_seen = !sda_sync;
                        end else begin
                           next_shreg = {shreg[6:0], sda_sync};
                        end
                     end
                     default: next_scl_oe = 1'b1;
                  endcase
               end
            endcase
         end
         if (timer == SECL_QUARTER_CYC - 8'h01) begin
            next_timer = 8'h00;
            next_phase = phase + 2'h1;
            if (phase == SECL_LAST_PHASE) begin
               if (state == SECL_E_BIT && bitn != SECL_ACK_BIT) begin
                  next_bitn = bitn + 4'h1;
               end else begin
                  next_state = SECL_E_IDLE;
                  next_done = 1'b1;
                  next_rdata = shreg;
               end
            end
         end else begin
            next_timer = timer + 8'h01;
         end
      end
   end

   // Data pin comes from outside, so two flops before use
   always_ff @(posedge core_clk_i) begin
      sda_meta <= twi.sda_pin;
      sda_sync <= sda_meta;
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= SECL_E_IDLE;
         phase <= 2'h0;
         timer <= 8'h00;
         bitn <= 4'h0;
         shreg <= 8'h00;
         cmd_r <= SECL_CMD_START;
         mack <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         done <= 1'b0;
         rdata <= 8'h00;
         ack_seen <= 1'b0;
      end else begin
         state <= next_state;
         phase <= next_phase;
         timer <= next_timer;
         bitn <= next_bitn;
         shreg <= next_shreg;
         cmd_r <= next_cmd_r;
         mack <= next_mack;
         scl_oe <= next_scl_oe;
         sda_oe <= next_sda_oe;
         done <= next_done;
         rdata <= next_rdata;
         ack_seen <= next_ack_seen;
      end
   end

endmodule

// File: logic/secl_twi_if.sv
`timescale 1ns/100ps
interface secl_twi_if;
   import secl_pkg::*;

   // Byte command from loader to engine
   logic cmd_valid;
   secl_cmd_t cmd;
   logic [7:0] wdata;
   logic master_ack;
   // Answer from engine
   logic done;
   logic [7:0] rdata;
   logic ack_seen;
   // Pin side
   logic scl_oe;
   logic sda_oe;
   logic sda_pin;

   modport loader (
      output cmd_valid, cmd, wdata, master_ack, sda_pin,
      input done, rdata, ack_seen, scl_oe, sda_oe
   );
   modport engine (
      input cmd_valid, cmd, wdata, master_ack, sda_pin,
      output done, rdata, ack_seen, scl_oe, sda_oe
   );
endinterface

// File: testbench/secl_eeprom_model.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Two-wire memory model, 32 bytes, device address 0xA0 / 0xA1
// ---------------------------------------------------------------
module secl_eeprom_model (
   // Line levels after the pull-ups
   input wire logic scl_i,
   input wire logic sda_i,
   // An absent part never acknowledges
   input wire logic present_i,
   // High while the model pulls the data line low
   output logic sda_pull_o
);
   logic [7:0] mem [0:31];
   logic [7:0] shift;
   logic [4:0] ptr;
   logic [4:0] first_addr;
   logic order_ok;
   int bitn;
   int phase; // 0 device, 1 word address, 2 data, 3 idle, 4 data next
   int n_served;

   initial begin
      sda_pull_o = 1'b0;
      bitn = 9;
      phase = 3;
      ptr = 5'h00;
   end

   // Start or stop: data moves while the clock is high
   always @(sda_i) begin
      if (scl_i === 1'b1) begin
         sda_pull_o = 1'b0;
         bitn = sda_i ? 9 : -1;
         phase = sda_i ? 3 : 0;
      end
   end

   // Sample on the rising edge; a master not-ack ends the read
   always @(posedge scl_i) begin
      if (bitn >= 0 && bitn < 8) shift = {shift[6:0], sda_i};
      if (bitn == 8 && phase == 2 && sda_i === 1'b1) phase = 3;
   end

   // Change the line only while the clock is low
   always @(negedge scl_i) begin
      if (bitn == 8) begin
         bitn = 0;
         if (phase == 2) ptr = ptr + 5'h01;
         if (phase == 4) phase = 2;
      end else if (bitn < 8) begin
         bitn = bitn + 1;
      end
      sda_pull_o = 1'b0;
      if (bitn == 8 && phase < 2) begin
         sda_pull_o = present_i && (phase == 1 || shift[7:1] == 7'h50);
         if (phase == 1) begin
            ptr = shift[4:0];
            first_addr = shift[4:0];
            phase = 3;
         end else begin
            phase = !sda_pull_o ? 3 : (shift[0] ? 4 : 1);
         end
      end
      // Serve data MSB first and log the address order
      if (phase == 2 && bitn < 8) begin
         sda_pull_o = !mem[ptr][7 - bitn];
         if (bitn == 0) begin
            if (ptr != n_served[4:0]) order_ok = 1'b0;
            n_served = n_served + 1;
         end
      end
   end
endmodule

// File: testbench/secl_loader_properties.sv
`timescale 1ns/100ps
// ---------------------------------------------------------------
// Port checker for the configuration loader
// ---------------------------------------------------------------
module secl_loader_properties (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic reset_i,
   // Serial clock enable
   input wire logic scl_oe_o,
   // Status and fields
   input wire logic pci_retry_o,
   input wire logic load_done_o,
   input wire logic eeprom_absent_o,
   input wire logic [3:0] max_latency_o,
   input wire logic [15:0] subsystem_id_o,
   input wire logic [4:0] card_info_pointer_o,
   input wire logic [7:0] phy_control_o,
   input wire logic cable_not_active_output_o
);
   import secl_pkg::*;
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (reset_i);

   // Reset itself must raise retry, so this one is not disabled by it
   chk_retry_at_reset: assert property (disable iff (1'b0) reset_i |=> pci_retry_o)
      else $error("retry low after reset");
   // Serial traffic means the image is still coming in
   chk_busy_retry: assert property (scl_oe_o |-> pci_retry_o && !load_done_o)
      else $error("serial traffic without retry");
   chk_retry_drop: assert property (load_done_o |-> ##[0:2] !pci_retry_o)
      else $error("retry held after load");
   chk_retry_early: assert property ($fell(pci_retry_o) |-> ##[0:2] load_done_o)
      else $error("retry released before load end");
   chk_done_sticky: assert property (load_done_o |=> load_done_o)
      else $error("load done fell");
   // Fields appear only once the whole image has been read
   chk_fields_busy: assert property (scl_oe_o |-> subsystem_id_o == 16'h0000
      && card_info_pointer_o == 5'h00 && max_latency_o == 4'h0) else $error("field early");
   chk_fields_frozen: assert property (!pci_retry_o |=> $stable(subsystem_id_o)
      && $stable(max_latency_o) && $stable(phy_control_o)) else $error("field changed");
   chk_cna_bit: assert property (cable_not_active_output_o == phy_control_o[SECL_BIT_CNA])
      else $error("cable output enable differs from bit 7");
   chk_absent_zero: assert property (eeprom_absent_o |-> phy_control_o == 8'h00
      && subsystem_id_o == 16'h0000) else $error("fields loaded without memory");

   // Main scenarios
   cover property (load_done_o && !eeprom_absent_o);
   cover property (load_done_o && eeprom_absent_o);
   cover property ($fell(pci_retry_o));
endmodule

bind secl_loader secl_loader_properties secl_loader_properties_i (
   .core_clk_i(core_clk_i), .reset_i(reset_i), .scl_oe_o(scl_oe_o),
   .pci_retry_o(pci_retry_o), .load_done_o(load_done_o), .eeprom_absent_o(eeprom_absent_o),
   .max_latency_o(max_latency_o), .subsystem_id_o(subsystem_id_o),
   .card_info_pointer_o(card_info_pointer_o), .phy_control_o(phy_control_o),
   .cable_not_active_output_o(cable_not_active_output_o)
);

// File: testbench/secl_loader_tb_top.sv
`timescale 1ns/100ps
module secl_loader_tb_top;
   import secl_pkg::*;
   // ---------------------------------------------------------------
   // Signals and instances
   // ---------------------------------------------------------------
   logic core_clk_i, reset_i, present, sda_pull;
   logic scl_o, scl_oe_o, sda_o, sda_oe_o, pci_retry_o, load_done_o, eeprom_absent_o;
   logic [3:0] max_latency_o, min_grant_o;
   logic [15:0] vendor_id_o, subsystem_id_o;
   logic enab_unfair_o, phy_programming_permit_o, enab_accel_o;
   logic [63:0] guid_o;
   logic async_tx_pipeline_disable_o, target_abort_disable_o, pme_d3_cold_o;
   logic [1:0] async_tx_threshold_o;
   logic [4:0] card_info_pointer_o;
   logic [7:0] phy_control_o;
   logic cable_not_active_output_o;
   int n_errors, n_checks;
   // Open drain with pull-ups: released lines read high
   wire scl_w = scl_oe_o ? scl_o : 1'b1;
   wire sda_w = (sda_oe_o ? sda_o : 1'b1) && !sda_pull;

   secl_loader secl_loader_i (
      .core_clk_i(core_clk_i), .reset_i(reset_i), .scl_o(scl_o), .scl_oe_o(scl_oe_o),
      .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pci_retry_o(pci_retry_o),
      .load_done_o(load_done_o), .eeprom_absent_o(eeprom_absent_o),
      .max_latency_o(max_latency_o), .min_grant_o(min_grant_o), .vendor_id_o(vendor_id_o),
      .subsystem_id_o(subsystem_id_o), .enab_unfair_o(enab_unfair_o),
      .phy_programming_permit_o(phy_programming_permit_o), .enab_accel_o(enab_accel_o),
      .guid_o(guid_o), .async_tx_pipeline_disable_o(async_tx_pipeline_disable_o),
      .async_tx_threshold_o(async_tx_threshold_o),
      .target_abort_disable_o(target_abort_disable_o), .pme_d3_cold_o(pme_d3_cold_o),
      .card_info_pointer_o(card_info_pointer_o), .phy_control_o(phy_control_o),
      .cable_not_active_output_o(cable_not_active_output_o)
   );
   secl_eeprom_model secl_eeprom_model_i (
      .scl_i(scl_w), .sda_i(sda_w), .present_i(present), .sda_pull_o(sda_pull)
   );

   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask

   task automatic wrap_up();
      $display("checks %0d, errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   // Image with the reserved and must-be bits kept as required
   task automatic set_image(input logic [7:0] b00, input logic [7:0] b14, input logic [7:0] b16);
      for (int i = 0; i < 32; i++) secl_eeprom_model_i.mem[i] = 8'h30 + 8'(i);
      secl_eeprom_model_i.mem[0] = b00;
      secl_eeprom_model_i.mem[5] = 8'hC2;
      secl_eeprom_model_i.mem[16] = 8'hB0;
      secl_eeprom_model_i.mem[17] = 8'h10;
      secl_eeprom_model_i.mem[20] = b14;
      secl_eeprom_model_i.mem[22] = b16;
   endtask

   // Reset for 8 cycles, then wait a bounded time for the load to end
   task automatic do_load(input logic fitted);
      int i;
      present = fitted;
      secl_eeprom_model_i.n_served = 0;
      secl_eeprom_model_i.order_ok = 1'b1;
      reset_i = 1'b1;
      repeat (8) @(negedge core_clk_i);
      reset_i = 1'b0;
      @(negedge core_clk_i);
      check("retry at start", pci_retry_o, 1'b1);
      i = 0;
      while (load_done_o !== 1'b1 && i < 40000) begin
         @(negedge core_clk_i);
         i++;
         if (i == 5000) check("retry mid load", pci_retry_o, 1'b1);
      end
      if (i >= 40000) begin
         n_errors++;
         wrap_up();
      end
      repeat (3) @(negedge core_clk_i);
      check("retry after load", pci_retry_o, 1'b0);
   endtask

   task automatic check_fields();
      logic [7:0] m [0:31];
      m = secl_eeprom_model_i.mem;
      check("max latency", max_latency_o, m[0][7:4]);
      check("min grant", min_grant_o, m[0][3:0]);
      check("subsystem id", subsystem_id_o, {m[4], m[3]});
      check("vendor id", vendor_id_o, {m[2], m[1]});
      check("link enables", {enab_unfair_o, phy_programming_permit_o, enab_accel_o}, 3'h7);
      check("card info pointer", card_info_pointer_o, m[20][7:3]);
      check("phy control", phy_control_o, m[22]);
      check("cable not active", cable_not_active_output_o, m[22][7]);
      check("tx pipeline", {async_tx_pipeline_disable_o, async_tx_threshold_o}, 3'h7);
      check("abort and pme", {target_abort_disable_o, pme_d3_cold_o}, {1'b1, m[18][7]});
      check("guid", guid_o, {m[10], m[9], m[8], m[7], m[14], m[13], m[12], m[11]});
      check("bytes served", 64'(secl_eeprom_model_i.n_served), 64'h17);
      check("read order", secl_eeprom_model_i.order_ok, 1'b1);
      check("start address", secl_eeprom_model_i.first_addr, 5'h00);
      check("absent flag", eeprom_absent_o, 1'b0);
      check("pins", {scl_o, sda_o}, 2'h0);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Full image, cable output wanted, reserved pointer bits set
   task automatic scen_full();
      set_image(8'hA5, 8'hAF, 8'h88);
      do_load(1'b1);
      check_fields();
   endtask

   // Second load back to back, output function off, pointer at zero
   task automatic scen_second();
      set_image(8'h3C, 8'h07, 8'h08);
      do_load(1'b1);
      check_fields();
   endtask

   // No memory fitted: retry still released, nothing loaded
   task automatic scen_absent();
      do_load(1'b0);
      check("absent flag", eeprom_absent_o, 1'b1);
      check("latency absent", {max_latency_o, min_grant_o}, 8'h00);
      check("subsystem absent", subsystem_id_o, 16'h0000);
      check("phy absent", {phy_control_o, card_info_pointer_o}, 13'h0000);
      check("bytes absent", 64'(secl_eeprom_model_i.n_served), 64'h0);
   endtask

   initial begin
      n_errors = 0;
      n_checks = 0;
      reset_i = 1'b1;
      present = 1'b1;
      scen_full();
      scen_second();
      scen_absent();
      wrap_up();
   end
endmodule
